/* File: common/cpd_pkg.sv */
// constants and types for the cable phy data path
package cpd_pkg;
    localparam int LANES = 8;
    localparam int PORTS = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_MHZ = 125;
    // link power indicator thresholds, in ns
    localparam int LPS_SHORT_NS = 1200;
    localparam int LPS_LONG_NS = 25000;
    localparam int LPS_SHORT_CYC = (LPS_SHORT_NS * CLK_MHZ + 999) / 1000;
    localparam int LPS_LONG_CYC = (LPS_LONG_NS * CLK_MHZ + 999) / 1000;
    // wake signal frequency, in kHz
    localparam int WAKE_KHZ = 6114;
    localparam int WAKE_HALF_CYC = (CLK_MHZ * 1000) / (2 * WAKE_KHZ);
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [11:0] CNT_RESET = 12'h000;
    typedef enum logic [1:0] {SPD_S100, SPD_S200, SPD_S400} cpd_speed_t;
    typedef enum logic [1:0] {LANE_2, LANE_4, LANE_8} cpd_lane_t;
    typedef enum logic [1:0] {LP_ACTIVE, LP_LOW, LP_DISABLED} cpd_lps_t;
endpackage

/* File: src/cpd_data_path.sv */
// fifo and top of the cable phy data path
//
// Function
// - capture link transmit lanes on system clock
// - serialize and data-strobe encode at speed
// - receiving port: transmitters off, receivers on
// - decode, regroup to lanes, deliver to link
// - repeat received bits on other active ports
// - divide clock, drive lowest to link
// - powerdown stops all but cable-inactive, port-connected and resume-request flags
// - isolation low turns transitions into pulses
// - disabled/suspended/disconnected port fully off
// - line comparators give arbitration, common-mode speed
// - bias and connect detect drive connection state
// - link power low: reset on return after short low, disable interface after long low
// - link-on while disabled drives periodic wake
`timescale 1ns/1ps
module cpd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clocking
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic flush,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    wire doWrite = inValid && inReady && ce;
    wire doRead = outValid && outReady && ce;
    assign inReady = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    always_ff @(posedge clock) begin
        if (doWrite) begin
            mem[wrPtr_r] <= inData;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else if (ce && flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doWrite) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doRead) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            count_r <= count_r + {{AW{1'b0}}, doWrite} - {{AW{1'b0}}, doRead};
        end
    end
endmodule

`timescale 1ns/1ps
module cpd_data_path
    import cpd_pkg::*;
(
    // clocking
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // device pins
    input wire logic powerDownPin,
    input wire logic isoSelect,
    output logic cableInactiveFlag,
    output logic pllRun,
    // link interface
    output logic linkClkOut,
    input wire cpd_lane_t laneMode,
    input wire cpd_speed_t linkSpeed,
    input wire logic linkTxValid,
    output logic linkTxReady,
    input wire logic [LANES-1:0] linkTxData,
    output logic linkRxValid,
    output logic [LANES-1:0] linkRxData,
    // link power and wake
    input wire logic linkPowerIndicator,
    input wire logic linkOnPacket,
    input wire logic busReset,
    output logic linkIfReset,
    output logic linkIfDisabled,
    input wire logic contenderWakeIn,
    output logic contenderWakeOut,
    output logic contenderWakeOe,
    output logic contenderStrap,
    // cable ports
    input wire logic [PORTS-1:0] portEnable,
    input wire logic [PORTS-1:0] portSuspend,
    input wire logic [PORTS-1:0] connectDetect,
    input wire logic [PORTS-1:0] biasDetect,
    input wire logic [PORTS-1:0] rxDataIn,
    input wire logic [PORTS-1:0] rxStrobeIn,
    input wire logic [PORTS-1:0] rxPacket,
    input wire logic [2*PORTS-1:0] lineState,
    input wire logic [2*PORTS-1:0] commonMode,
    output logic [PORTS-1:0] txDataOut,
    output logic [PORTS-1:0] txStrobeOut,
    output logic [PORTS-1:0] txEnable,
    output logic [PORTS-1:0] rxEnable,
    output logic [PORTS-1:0] biasEnable,
    output logic [PORTS-1:0] portConnected,
    output logic [PORTS-1:0] resumeRequest,
    output logic [2*PORTS-1:0] arbStatus,
    output cpd_speed_t nextSpeed
);
    // pin synchronisers
    localparam int SW = 7 * PORTS + 4 * PORTS + 4;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    wire [SW-1:0] pinsIn = {powerDownPin, isoSelect, linkPowerIndicator, contenderWakeIn,
        portEnable, portSuspend, connectDetect, biasDetect, rxDataIn, rxStrobeIn,
        rxPacket, lineState, commonMode};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (ce) begin
            sync1_r <= pinsIn;
            sync2_r <= sync1_r;
        end
    end
    wire pdS, isoS, lpsS, wakeInS;
    wire [PORTS-1:0] enS, suspS, conS, biasS, rxDS, rxSS, rxPktS;
    wire [2*PORTS-1:0] lineS, cmS;
    assign {pdS, isoS, lpsS, wakeInS, enS, suspS, conS, biasS, rxDS, rxSS, rxPktS,
        lineS, cmS} = sync2_r;

    // cable-inactive logic keeps running through powerdown
    assign cableInactiveFlag = ~|biasS;
    assign pllRun = ~pdS;
    wire run = ce && !pdS;

    // strap caught once the synchroniser holds the pin level
    logic [1:0] strapCnt_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strapCnt_r <= 2'h0;
            contenderStrap <= 1'b0;
        end else if (ce && strapCnt_r != 2'h3) begin
            strapCnt_r <= strapCnt_r + 2'h1;
            if (strapCnt_r == 2'h2) begin
                contenderStrap <= wakeInS;
            end
        end
    end

    // clock divider and bit ticks
    logic [1:0] div_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_r <= DIV_RESET;
        end else if (ce) begin
            div_r <= pdS ? DIV_RESET : div_r + 2'h1;
        end
    end
    assign linkClkOut = div_r[1];
    function automatic logic speedTick(cpd_speed_t s, logic [1:0] d);
        logic t;
        t = (s == SPD_S400) || (s == SPD_S200 && !d[0]) || (d == 2'h0);
        return t;
    endfunction
    wire [3:0] laneCnt = (laneMode == LANE_2) ? 4'h2 : (laneMode == LANE_4) ? 4'h4 : 4'h8;
    wire [LANES-1:0] laneMask = (laneMode == LANE_2) ? 8'h03 :
        (laneMode == LANE_4) ? 8'h0f : 8'hff;

    // port state, arbitration and speed
    wire [PORTS-1:0] portActive = enS & ~suspS & conS & {PORTS{!pdS}};
    wire [PORTS-1:0] rxing = rxPktS & portActive;
    wire repeating = |rxing;
    wire rxPort = rxing[1];
    assign portConnected = conS;
    assign resumeRequest = suspS & biasS & conS;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arbStatus <= '0;
            nextSpeed <= SPD_S100;
        end else if (run) begin
            arbStatus <= lineS & {{2{portActive[1]}}, {2{portActive[0]}}};
            if (!repeating && |portActive) begin
                nextSpeed <= cpd_speed_t'(portActive[1] ? cmS[3:2] : cmS[1:0]);
            end
        end
    end

    // transmit fifo and serializer
    logic fifoValid;
    logic [LANES-1:0] fifoData;
    logic [LANES-1:0] shift_r;
    logic [3:0] bitsLeft_r;
    wire serTick = speedTick(linkSpeed, div_r);
    wire serLoad = fifoValid && bitsLeft_r == 4'h0 && !repeating && |portActive;
    cpd_fifo #(.WIDTH(LANES), .DEPTH(FIFO_DEPTH)) txFifo (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .flush(pdS),
        .inValid(linkTxValid && !pdS),
        .inReady(linkTxReady),
        .inData(linkTxData & laneMask),
        .outValid(fifoValid),
        .outReady(serLoad && ce),
        .outData(fifoData)
    );
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shift_r <= DATA_RESET;
            bitsLeft_r <= 4'h0;
        end else if (run) begin
            if (serLoad) begin
                shift_r <= fifoData;
                bitsLeft_r <= laneCnt;
            end else if (bitsLeft_r != 4'h0 && serTick) begin
                shift_r <= {1'b0, shift_r[LANES-1:1]};
                bitsLeft_r <= bitsLeft_r - 4'h1;
            end
        end else if (ce) begin
            bitsLeft_r <= 4'h0;
        end
    end
    wire serActive = bitsLeft_r != 4'h0;

    // per-port decode and encode
    logic [PORTS-1:0] rxBitValid;
    logic [PORTS-1:0] rxBit;
    logic [PORTS-1:0] prevXor_r;
    genvar p;
    generate
        for (p = 0; p < PORTS; p++) begin : gPort
            wire other = rxing[PORTS-1-p];
            wire rpt = other && portActive[p] && !rxing[p];
            wire txOn = portActive[p] && !rxing[p] && (rpt || (serActive && !repeating));
            wire bitGo = rpt ? rxBitValid[PORTS-1-p] : (serActive && serTick && !repeating);
            wire bitVal = rpt ? rxBit[PORTS-1-p] : shift_r[0];
            assign rxBitValid[p] = rxing[p] && ((rxDS[p] ^ rxSS[p]) != prevXor_r[p]);
            assign rxBit[p] = rxDS[p];
            assign rxEnable[p] = portActive[p] && !txEnable[p];
            assign biasEnable[p] = portActive[p];
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    prevXor_r[p] <= 1'b0;
                    txDataOut[p] <= 1'b0;
                    txStrobeOut[p] <= 1'b0;
                    txEnable[p] <= 1'b0;
                end else if (ce) begin
                    prevXor_r[p] <= rxDS[p] ^ rxSS[p];
                    txEnable[p] <= txOn && !pdS;
                    if (!txOn || pdS) begin
                        txDataOut[p] <= 1'b0;
                        txStrobeOut[p] <= 1'b0;
                    end else if (bitGo) begin
                        txDataOut[p] <= bitVal;
                        txStrobeOut[p] <= txStrobeOut[p] ^ (bitVal == txDataOut[p]);
                    end
                end
            end
        end
    endgenerate

    // deserializer and isolation output
    logic [LANES-1:0] des_r;
    logic [3:0] desCnt_r;
    logic [LANES-1:0] word_r;
    logic [LANES-1:0] wordPrev_r;
    logic wordNew_r;
    wire desBit = rxBit[rxPort];
    wire desGo = rxBitValid[rxPort];
    wire [LANES-1:0] desNext = {desBit, des_r[LANES-1:1]};
    wire desDone = desGo && (desCnt_r + 4'h1 == laneCnt);
    wire [LANES-1:0] desWord = (desNext >> (4'h8 - laneCnt)) & laneMask;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            des_r <= DATA_RESET;
            desCnt_r <= 4'h0;
            word_r <= DATA_RESET;
            wordPrev_r <= DATA_RESET;
            wordNew_r <= 1'b0;
            linkRxData <= DATA_RESET;
            linkRxValid <= 1'b0;
        end else if (ce) begin
            wordNew_r <= run && desDone;
            wordPrev_r <= word_r;
            linkRxValid <= wordNew_r && !linkIfDisabled;
            linkRxData <= isoS ? word_r : (word_r ^ wordPrev_r);
            if (!run || !repeating) begin
                desCnt_r <= 4'h0;
            end else if (desGo) begin
                des_r <= desNext;
                desCnt_r <= desDone ? 4'h0 : desCnt_r + 4'h1;
            end
            if (run && desDone) begin
                word_r <= desWord;
            end
        end
    end

    // link power supervision and wake
    cpd_lps_t lps_r;
    logic [11:0] lowCnt_r;
    logic [3:0] wakeCnt_r;
    logic wakeOn_r;
    logic wakeLvl_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lps_r <= LP_ACTIVE;
            lowCnt_r <= CNT_RESET;
            linkIfReset <= 1'b0;
        end else if (run) begin
            linkIfReset <= 1'b0;
            case (lps_r)
                LP_ACTIVE: begin
                    lowCnt_r <= CNT_RESET;
                    if (!lpsS) begin
                        lps_r <= LP_LOW;
                    end
                end
                LP_LOW: begin
                    lowCnt_r <= lowCnt_r + 12'h001;
                    if (lpsS) begin
                        lps_r <= LP_ACTIVE;
                        linkIfReset <= lowCnt_r >= LPS_SHORT_CYC[11:0];
                    end else if (lowCnt_r >= LPS_LONG_CYC[11:0]) begin
                        lps_r <= LP_DISABLED;
                    end
                end
                LP_DISABLED: begin
                    if (lpsS) begin
                        lps_r <= LP_ACTIVE;
                    end
                end
                default: begin
                    lps_r <= LP_ACTIVE;
                end
            endcase
        end
    end
    assign linkIfDisabled = (lps_r == LP_DISABLED);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wakeOn_r <= 1'b0;
            wakeCnt_r <= 4'h0;
            wakeLvl_r <= 1'b0;
        end else if (run) begin
            if (lpsS || busReset) begin
                wakeOn_r <= 1'b0;
            end else if (linkOnPacket && linkIfDisabled) begin
                wakeOn_r <= 1'b1;
            end
            if (!wakeOn_r || wakeCnt_r == 4'(WAKE_HALF_CYC - 1)) begin
                wakeCnt_r <= 4'h0;
                wakeLvl_r <= wakeOn_r && !wakeLvl_r;
            end else begin
                wakeCnt_r <= wakeCnt_r + 4'h1;
            end
        end
    end
    assign contenderWakeOut = wakeLvl_r;
    assign contenderWakeOe = wakeOn_r;

    // checks
    sequence sLpsLongLow;
        ce && !pdS && lps_r == LP_LOW && !lpsS && lowCnt_r >= LPS_LONG_CYC[11:0];
    endsequence
    sequence sWakeEdge;
        ce && !pdS && wakeOn_r && wakeCnt_r == 4'(WAKE_HALF_CYC - 1) && !(lpsS || busReset);
    endsequence
    a_pd_tx_off: assert property (@(posedge clock) disable iff (rst)
        pdS && ce |=> txEnable == '0 && txDataOut == '0 && rxEnable == '0)
        else $error("transmit active in powerdown");
    a_inactive_port: assert property (@(posedge clock) disable iff (rst)
        !portActive[0] |-> !rxEnable[0] && !biasEnable[0] ##1 (!ce || !txEnable[0] || portActive[0]))
        else $error("inactive port not off");
    a_rx_tx_off: assert property (@(posedge clock) disable iff (rst)
        ce && rxing[1] |=> !txEnable[1] || !$past(rxing[1]))
        else $error("receiving port transmits");
    a_lane_mask: assert property (@(posedge clock) disable iff (rst)
        laneMode == LANE_2 && isoS && ce ##1 (laneMode == LANE_2) [*2] |-> linkRxData[7:2] == 6'h00)
        else $error("upper lanes not driven low");
    a_lps_disable: assert property (@(posedge clock) disable iff (rst)
        sLpsLongLow |=> (!ce || pdS || linkIfDisabled))
        else $error("interface not disabled after long low");
    a_wake_toggle: assert property (@(posedge clock) disable iff (rst)
        sWakeEdge |=> (!ce || contenderWakeOut != $past(contenderWakeOut)))
        else $error("wake output did not toggle");
    a_repeat_bit: assert property (@(posedge clock) disable iff (rst)
        ce && !pdS && rxBitValid[1] && portActive[0] && !rxing[0] |=> txDataOut[0] == $past(rxBit[1]))
        else $error("bit not repeated");
    a_link_clock: assert property (@(posedge clock) disable iff (rst)
        ce && !pdS && div_r == 2'h1 ##1 ce && !pdS |-> linkClkOut ##1 linkClkOut)
        else $error("link clock divider wrong");
endmodule

/* File: verif/cpd_link_model.sv */
// link-layer controller model on the parallel link interface
`timescale 1ns/1ps
module cpd_link_model
    import cpd_pkg::*;
(
    // clocking
    input wire logic clock,
    // transmit lanes
    output logic linkTxValid,
    input wire logic linkTxReady,
    output logic [LANES-1:0] linkTxData,
    // receive lanes
    input wire logic linkRxValid,
    input wire logic [LANES-1:0] linkRxData
);
    logic [LANES-1:0] rxWords[$];
    int stuck = 0;
    initial begin
        linkTxValid = 1'b0;
        linkTxData = 8'h00;
    end
    // idle cycles first when slow, then hold the word until taken
    task automatic sendWord(input logic [LANES-1:0] w, input int idle);
        logic ok;
        ok = 1'b0;
        if (idle > 0) begin
            linkTxValid = 1'b0;
            repeat (idle) @(posedge clock);
            #1;
        end
        linkTxValid = 1'b1;
        linkTxData = w;
        for (int n = 0; n < 100 && !ok; n++) begin
            @(negedge clock);
            ok = (linkTxReady === 1'b1);
            @(posedge clock);
        end
        #1;
        if (!ok) stuck++;
    endtask
    task automatic stopTx();
        linkTxValid = 1'b0;
    endtask
    // words delivered on the system clock
    always @(posedge clock) begin
        if (linkRxValid === 1'b1) rxWords.push_back(linkRxData);
    end
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the cable phy data path
`timescale 1ns/1ps
module tb_top;
    import cpd_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic powerDownPin = 1'b0;
    logic isoSelect = 1'b1;
    logic linkPowerIndicator = 1'b1;
    logic linkOnPacket = 1'b0;
    logic busReset = 1'b0;
    logic contenderWakeIn = 1'b1;
    cpd_lane_t laneMode = LANE_8;
    cpd_speed_t linkSpeed = SPD_S400;
    logic [PORTS-1:0] portEnable = 2'h3;
    logic [PORTS-1:0] portSuspend = 2'h0;
    logic [PORTS-1:0] connectDetect = 2'h3;
    logic [PORTS-1:0] biasDetect = 2'h3;
    logic [PORTS-1:0] rxDataIn = 2'h0;
    logic [PORTS-1:0] rxStrobeIn = 2'h0;
    logic [PORTS-1:0] rxPacket = 2'h0;
    logic [2*PORTS-1:0] lineState = 4'h0;
    logic [2*PORTS-1:0] commonMode = 4'h0;
    logic linkTxValid, linkTxReady, linkRxValid, cableInactiveFlag, pllRun, linkClkOut;
    logic linkIfReset, linkIfDisabled, contenderWakeOut, contenderWakeOe, contenderStrap;
    logic [LANES-1:0] linkTxData, linkRxData, w;
    logic [PORTS-1:0] txDataOut, txStrobeOut, txEnable, rxEnable, biasEnable;
    logic [PORTS-1:0] portConnected, resumeRequest;
    logic [2*PORTS-1:0] arbStatus;
    cpd_speed_t nextSpeed;
    int fail_count = 0;
    int check_count = 0;
    logic txBits[$];
    logic expBits[$];
    logic [LANES-1:0] expWords[$];
    logic prevX = 1'b0;
    logic chkGap = 1'b0;
    logic a, lk;
    logic [1:0] spd = 2'h0;
    logic [LANES-1:0] isoAcc, lastW;
    int txIdx = 0;
    int gapCnt = 0;
    int n;
    int lowLen[3] = '{120, 180, 3000};

    cpd_data_path dut_u (.clock, .rst, .ce, .powerDownPin, .isoSelect, .cableInactiveFlag,
        .pllRun, .linkClkOut, .laneMode, .linkSpeed, .linkTxValid, .linkTxReady, .linkTxData,
        .linkRxValid, .linkRxData, .linkPowerIndicator, .linkOnPacket, .busReset, .linkIfReset,
        .linkIfDisabled, .contenderWakeIn, .contenderWakeOut, .contenderWakeOe, .contenderStrap,
        .portEnable, .portSuspend, .connectDetect, .biasDetect, .rxDataIn, .rxStrobeIn,
        .rxPacket, .lineState, .commonMode, .txDataOut, .txStrobeOut, .txEnable, .rxEnable,
        .biasEnable, .portConnected, .resumeRequest, .arbStatus, .nextSpeed);
    cpd_link_model lnk (.clock, .linkTxValid, .linkTxReady, .linkTxData, .linkRxValid,
        .linkRxData);

    initial begin
        forever #4 clock = ~clock;
    end
    function automatic int laneCnt(cpd_lane_t m);
        return 2 << m;
    endfunction
    function automatic int spdGap(cpd_speed_t s);
        return 4 >> s;
    endfunction
    task automatic tick(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // port 0 cable bits: one bit per data-strobe change
    always @(posedge clock) begin
        if (txEnable[0] === 1'b1 && (txDataOut[0] ^ txStrobeOut[0]) !== prevX) begin
            if (chkGap && txIdx % laneCnt(laneMode) != 0) chk(gapCnt, spdGap(linkSpeed));
            txBits.push_back(txDataOut[0]);
            txIdx++;
            gapCnt = 0;
        end
        prevX = txDataOut[0] ^ txStrobeOut[0];
        gapCnt++;
    end
    // collects isolation pulses on the receive lanes
    always @(posedge clock) begin
        if (isoSelect === 1'b0) isoAcc |= linkRxData;
    end
    task automatic drain(input int bound);
        for (n = 0; n < bound && txBits.size() < expBits.size(); n++) tick(1);
        if (n == bound) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, txBits.size(), expBits.size());
            test_done();
        end
        tick(8);
        chk(txBits.size(), expBits.size());
        foreach (expBits[i]) chk(txBits[i], expBits[i]);
        txBits.delete();
        expBits.delete();
        txIdx = 0;
    endtask
    task automatic send(input cpd_lane_t m, input int idle);
        w = 8'($urandom());
        for (int i = 0; i < laneCnt(m); i++) expBits.push_back(w[i]);
        lnk.sendWord(w, idle);
    endtask
    // data-strobe encode one word onto the port 1 receive pins
    task automatic rxWord(input cpd_lane_t m);
        w = 8'($urandom());
        expWords.push_back(w & 8'((1 << laneCnt(m)) - 1));
        for (int i = 0; i < laneCnt(m); i++) begin
            expBits.push_back(w[i]);
            if (w[i] === rxDataIn[1]) rxStrobeIn[1] = ~rxStrobeIn[1];
            rxDataIn[1] = w[i];
            tick(8);
        end
    endtask

    initial begin
        void'($urandom(32'h1c6feb7f));
        repeat (16) @(posedge clock);
        #1;
        rst = 1'b0;
        tick(4);
        chk({linkTxReady, pllRun, txEnable, linkRxValid}, 16'h18);
        chk(contenderStrap, 1'b1);
        for (int k = 0; k < 12; k++) begin
            {portEnable, portSuspend, connectDetect, biasDetect, lineState} = 12'($urandom());
            commonMode = 4'($urandom());
            if (k < 2) {portEnable, portSuspend, connectDetect, biasDetect} = k ? 8'h00 : 8'hcf;
            tick(4);
            for (int p = 0; p < PORTS; p++) begin
                a = portEnable[p] & connectDetect[p] & ~portSuspend[p];
                chk({biasEnable[p], rxEnable[p] & ~a, txEnable[p]}, {a, 2'b00});
                chk(arbStatus[2*p+:2], a ? lineState[2*p+:2] : 2'b00);
            end
            if (a | (portEnable[0] & connectDetect[0] & ~portSuspend[0])) begin
                spd = a ? commonMode[3:2] : commonMode[1:0];
            end
            chk(nextSpeed, spd);
            chk(resumeRequest, portSuspend & connectDetect & biasDetect);
            chk(portConnected, connectDetect);
            chk(cableInactiveFlag, ~|biasDetect);
        end
        {portEnable, portSuspend, connectDetect, biasDetect} = 8'hcf;
        tick(4);
        n = 0;
        lk = linkClkOut;
        repeat (40) begin
            tick(1);
            n += (linkClkOut !== lk);
            lk = linkClkOut;
        end
        chk(n, 20);
        lk = linkClkOut;
        ce = 1'b0;
        tick(6);
        chk(linkClkOut, lk);
        ce = 1'b1;
        powerDownPin = 1'b1;
        biasDetect = 2'h1;
        tick(4);
        chk({pllRun, linkClkOut, txEnable, rxEnable, biasEnable, cableInactiveFlag}, 0);
        powerDownPin = 1'b0;
        biasDetect = 2'h3;
        portEnable = 2'h0;
        tick(4);
        $display("test ports done");
        linkSpeed = SPD_S100;
        for (n = 0; n < 20 && linkTxReady === 1'b1; n++) send(LANE_8, 0);
        lnk.stopTx();
        chk(n, FIFO_DEPTH);
        chkGap = 1'b1;
        portEnable = 2'h1;
        drain(3000);
        for (int k = 0; k < 9; k++) begin
            laneMode = cpd_lane_t'(k % 3);
            linkSpeed = cpd_speed_t'(k / 3);
            tick(2);
            repeat (3) send(laneMode, $urandom_range(2));
            lnk.stopTx();
            drain(500);
        end
        $display("test transmit done");
        chkGap = 1'b0;
        portEnable = 2'h3;
        for (int k = 0; k < 3; k++) begin
            laneMode = cpd_lane_t'(k);
            rxPacket = 2'h2;
            tick(4);
            chk({rxEnable[1], txEnable[1]}, 2'b10);
            repeat (2) rxWord(laneMode);
            tick(8);
            rxPacket = 2'h0;
            chk(lnk.rxWords.size(), expWords.size());
            foreach (expWords[i]) chk(lnk.rxWords[i], expWords[i]);
            chk(linkRxData, expWords[1]);
            drain(50);
            lnk.rxWords.delete();
            expWords.delete();
        end
        isoSelect = 1'b0;
        rxPacket = 2'h2;
        tick(4);
        lastW = w;
        isoAcc = 8'h00;
        rxWord(LANE_8);
        chk(isoAcc, lastW ^ w);
        chk(linkRxData, 8'h00);
        isoSelect = 1'b1;
        rxPacket = 2'h0;
        tick(8);
        txBits.delete();
        expBits.delete();
        $display("test receive done");
        for (int k = 0; k < 3; k++) begin
            linkPowerIndicator = 1'b0;
            tick(lowLen[k]);
            chk(linkIfDisabled, 1'b0);
            linkPowerIndicator = 1'b1;
            a = 1'b0;
            repeat (8) begin
                tick(1);
                a |= linkIfReset;
            end
            chk(a, k != 0);
        end
        linkPowerIndicator = 1'b0;
        tick(3200);
        chk(linkIfDisabled, 1'b1);
        for (int k = 0; k < 2; k++) begin
            linkOnPacket = 1'b1;
            tick(1);
            linkOnPacket = 1'b0;
            tick(2);
            chk(contenderWakeOe, 1'b1);
            if (k == 0) begin
                lk = contenderWakeOut;
                for (n = 0; n < 30 && contenderWakeOut === lk; n++) tick(1);
                lk = contenderWakeOut;
                for (n = 0; n < 30 && contenderWakeOut === lk; n++) tick(1);
                chk(n, WAKE_HALF_CYC);
                busReset = 1'b1;
            end
            else linkPowerIndicator = 1'b1;
            tick(4);
            busReset = 1'b0;
            chk(contenderWakeOe, 1'b0);
        end
        chk(linkIfDisabled, 1'b0);
        chk(lnk.stuck, 0);
        $display("test link power done");
        test_done();
    end
endmodule
